// File: common/gpclr_pkg.sv
`default_nettype none
package gpclr_pkg;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned DATA_W       = 32;
  // register byte addresses
  localparam logic [31:0] PORT1_CLR_ADDR = 32'hFFFF0D38;
  localparam logic [31:0] PORT2_CLR_ADDR = 32'hFFFF0D48;
  localparam logic [31:0] PORT1_SET_ADDR = 32'hFFFF0D34;
  localparam logic [31:0] PORT2_SET_ADDR = 32'hFFFF0D44;
  // pin fields in the clear/set words
  localparam int unsigned P1_LO        = 16;
  localparam int unsigned P1_W         = 2;
  localparam int unsigned P2A_LO       = 16;
  localparam int unsigned P2A_W        = 2;
  localparam int unsigned P2B_LO       = 21;
  localparam int unsigned P2B_W        = 2;
  localparam int unsigned P2_W         = 4;
  // latch reset value
  localparam logic [1:0]  P1_RST       = 2'h0;
  localparam logic [3:0]  P2_RST       = 4'h0;
  localparam logic [31:0] READ_ZERO    = 32'h00000000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } gpclr_req_s;
endpackage
`default_nettype wire

// File: core/gpclr_top.sv
// What this block does
// R1 - port-one clear register, write only, 0xFFFF0D38
// R2 - bit 17 drives port-one pin 1 low
// R3 - bit 16 drives port-one pin 0 low
// R4 - zero bits leave pins unchanged
// R5 - only pins written one change
// R6 - software writes reserved bits as zero
// R7 - port-two clear register, write only, 0xFFFF0D48
// R8 - bit 22 drives port-two pin 6 low
// R9 - bit 21 drives port-two pin 5 low
// R10 - bit 17 drives port-two pin 1 low
// R11 - bit 16 drives port-two pin 0 low
// R12 - set registers drive same latches high
// R13 - reads return zero, no side effect
`default_nettype none
module gpclr_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // register port
  input  wire gpclr_pkg::gpclr_req_s bus_req,
  output logic [31:0]               bus_rdata,
  // pin output latches: port1 {pin1,pin0}, port2 {pin6,pin5,pin1,pin0}
  output logic [1:0]                port1_out,
  output logic [3:0]                port2_out
);
  // one flop per pin latch, so each pin's update stands alone
  logic        p1_pin0_reg;
  logic        p1_pin1_reg;
  logic        p2_pin0_reg;
  logic        p2_pin1_reg;
  logic        p2_pin5_reg;
  logic        p2_pin6_reg;
  logic [31:0] rdata_reg;

  // decoded register writes
  logic        w_p1clr;
  logic        w_p2clr;
  logic        w_p1set;
  logic        w_p2set;

  // per-pin strobes, low unless that pin's bit is written one
  logic [1:0]  p1_clr;
  logic [1:0]  p1_set;
  logic [3:0]  p2_clr;
  logic [3:0]  p2_set;

  function automatic logic addr_hit(input gpclr_pkg::gpclr_req_s req,
                                    input logic [31:0]          base);
    addr_hit = req.wr && (req.addr == base);
  endfunction

  function automatic logic [1:0] p1_bits(input logic [31:0] d);
    p1_bits = d[gpclr_pkg::P1_LO +: gpclr_pkg::P1_W];
  endfunction

  function automatic logic [3:0] p2_bits(input logic [31:0] d);
    p2_bits = {d[gpclr_pkg::P2B_LO +: gpclr_pkg::P2B_W],
               d[gpclr_pkg::P2A_LO +: gpclr_pkg::P2A_W]};
  endfunction

  assign w_p1clr = addr_hit(bus_req, gpclr_pkg::PORT1_CLR_ADDR); // [R1]
  assign w_p2clr = addr_hit(bus_req, gpclr_pkg::PORT2_CLR_ADDR); // [R7]
  assign w_p1set = addr_hit(bus_req, gpclr_pkg::PORT1_SET_ADDR); // [R12]
  assign w_p2set = addr_hit(bus_req, gpclr_pkg::PORT2_SET_ADDR); // [R12]

  // only ones act, so software needs no read-modify-write;
  // reserved bits never reach a latch whatever software writes [R6]
  assign p1_clr = w_p1clr ? p1_bits(bus_req.wdata) : 2'h0; // [R4] [R5]
  assign p1_set = w_p1set ? p1_bits(bus_req.wdata) : 2'h0; // [R12]
  assign p2_clr = w_p2clr ? p2_bits(bus_req.wdata) : 4'h0; // [R4] [R5]
  assign p2_set = w_p2set ? p2_bits(bus_req.wdata) : 4'h0; // [R12]

  // port-one pin 0
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p1_pin0_reg <= gpclr_pkg::P1_RST[0];
    end else if (p1_clr[0]) begin
      p1_pin0_reg <= 1'h0; // [R3]
    end else if (p1_set[0]) begin
      p1_pin0_reg <= 1'h1; // [R12]
    end
  end

  // port-one pin 1
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p1_pin1_reg <= gpclr_pkg::P1_RST[1];
    end else if (p1_clr[1]) begin
      p1_pin1_reg <= 1'h0; // [R2]
    end else if (p1_set[1]) begin
      p1_pin1_reg <= 1'h1; // [R12]
    end
  end

  // port-two pin 0
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p2_pin0_reg <= gpclr_pkg::P2_RST[0];
    end else if (p2_clr[0]) begin
      p2_pin0_reg <= 1'h0; // [R11]
    end else if (p2_set[0]) begin
      p2_pin0_reg <= 1'h1; // [R12]
    end
  end

  // port-two pin 1
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p2_pin1_reg <= gpclr_pkg::P2_RST[1];
    end else if (p2_clr[1]) begin
      p2_pin1_reg <= 1'h0; // [R10]
    end else if (p2_set[1]) begin
      p2_pin1_reg <= 1'h1; // [R12]
    end
  end

  // port-two pin 5
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p2_pin5_reg <= gpclr_pkg::P2_RST[2];
    end else if (p2_clr[2]) begin
      p2_pin5_reg <= 1'h0; // [R9]
    end else if (p2_set[2]) begin
      p2_pin5_reg <= 1'h1; // [R12]
    end
  end

  // port-two pin 6
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p2_pin6_reg <= gpclr_pkg::P2_RST[3];
    end else if (p2_clr[3]) begin
      p2_pin6_reg <= 1'h0; // [R8]
    end else if (p2_set[3]) begin
      p2_pin6_reg <= 1'h1; // [R12]
    end
  end

  // write-only registers read as zero; a read touches no latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= gpclr_pkg::READ_ZERO;
    end else begin
      rdata_reg <= gpclr_pkg::READ_ZERO; // [R13]
    end
  end

  assign port1_out = {p1_pin1_reg, p1_pin0_reg};
  assign port2_out = {p2_pin6_reg, p2_pin5_reg, p2_pin1_reg, p2_pin0_reg};
  assign bus_rdata = rdata_reg;
endmodule // gpclr_top
`default_nettype wire

// File: dv/gpclr_chk.sv
`default_nettype none
module gpclr_chk (
  input wire logic clk, resetn,
  input wire gpclr_pkg::gpclr_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [1:0] port1_out,
  input wire logic [3:0] port2_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire w1 = bus_req.wr && bus_req.addr == gpclr_pkg::PORT1_CLR_ADDR;
  wire w2 = bus_req.wr && bus_req.addr == gpclr_pkg::PORT2_CLR_ADDR;
  wire [31:0] d = bus_req.wdata;
  wire s1 = bus_req.wr && bus_req.addr == gpclr_pkg::PORT1_SET_ADDR;
  wire s2 = bus_req.wr && bus_req.addr == gpclr_pkg::PORT2_SET_ADDR;
  a_p1_b1: assert property (w1 && d[17] |=> !port1_out[1]) else $error("p1b1");
  a_p1_b0: assert property (w1 && d[16] |=> !port1_out[0]) else $error("p1b0");
  a_p2_b3: assert property (w2 && d[22] |=> !port2_out[3]) else $error("p2b3");
  a_p2_b2: assert property (w2 && d[21] |=> !port2_out[2]) else $error("p2b2");
  a_p2_b1: assert property (w2 && d[17] |=> !port2_out[1]) else $error("p2b1");
  a_p2_b0: assert property (w2 && d[16] |=> !port2_out[0]) else $error("p2b0");
  a_p1_keep: assert property (w1 |=> port1_out == ($past(port1_out) & ~$past(d[17:16])))
    else $error("p1");
  a_rd_quiet: assert property (bus_req.rd |=> bus_rdata == 0 && $stable(port2_out))
    else $error("rd");
  a_p2_keep: assert property (w2 |=> port2_out == ($past(port2_out) &
    ~{$past(d[22:21]), $past(d[17:16])})) else $error("p2");
  a_p1_set: assert property (s1 |=> port1_out == ($past(port1_out) | $past(d[17:16])))
    else $error("p1 set");
  a_p2_set: assert property (s2 |=> port2_out == ($past(port2_out) |
    {$past(d[22:21]), $past(d[17:16])})) else $error("p2 set");
  a_rd_p1: assert property (bus_req.rd |=> $stable(port1_out)) else $error("rd p1");
endmodule // gpclr_chk
`default_nettype wire

// File: dv/gpclr_pins.sv
`default_nettype none
// pads follow the latches; no pull or contention modelled
module gpclr_pins (input wire logic [1:0] port1_out, input wire logic [3:0] port2_out,
  output logic [5:0] level);
  timeunit 1ns; timeprecision 1ns;
  assign level = {port2_out, port1_out};
endmodule // gpclr_pins
`default_nettype wire

// File: dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, resetn = 0; logic [31:0] a, d, rd; logic [1:0] p1; logic [3:0] p2;
  logic [5:0] lv, ex = 0; logic [15:0] r = 16'h0690; int bad_count = 0, check_count = 0;
  gpclr_pkg::gpclr_req_s q = '0;
  always #5 clk = ~clk;
  gpclr_top i_gpclr_top (.clk, .resetn, .bus_req(q), .bus_rdata(rd), .port1_out(p1),
    .port2_out(p2));
  gpclr_pins i_gpclr_pins (.port1_out(p1), .port2_out(p2), .level(lv));
  function automatic logic [5:0] f(logic [5:0] e, logic [31:0] a, d);
    logic [5:0] b = {d[22:21], d[17:16], d[17:16]};
    case (a)
      gpclr_pkg::PORT1_SET_ADDR: e[1:0] |= b[1:0];
      gpclr_pkg::PORT1_CLR_ADDR: e[1:0] &= ~b[1:0];
      gpclr_pkg::PORT2_SET_ADDR: e[5:2] |= b[5:2];
      gpclr_pkg::PORT2_CLR_ADDR: e[5:2] &= ~b[5:2];
      default: ;
    endcase
    return e;
  endfunction
  task chk(string n, logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      // a second reset in mid-run must bring every latch back low
      resetn <= !(i inside {[150:152]});
      r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
      // some addresses land off the map to prove they are ignored
      a = 32'hFFFF0D34 + {r[1], 4'h0} + {r[0], 2'h0} ^ {r[6:4] == 7, 8'h0};
      d = {9'h0, r[10:9], 3'h0, r[8:7], 16'h0};
      q <= {a, d, !(r[2] & r[3]), r[2] & r[3]};
      #1 chk("pins", lv, ex);
      chk("rdata", rd, 0);
      if (!resetn) ex = 0;
      else if (!q.rd) ex = f(ex, a, d);
    end
    give_verdict;
  end
  initial begin
    #9000 bad_count++;
    give_verdict;
  end
endmodule // testbench
bind gpclr_top gpclr_chk i_gpclr_chk (.clk, .resetn, .bus_req, .bus_rdata, .port1_out,
  .port2_out);
`default_nettype wire
